//--- core/ssc_cfg.svh
// constants for the serial switch control port
// assumes inclusion by bare name from core files
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
// control word width, one bit per switch
`define SSC_WORD_W 8
// switch register and shift register reset value
`define SSC_WORD_RST 8'h00
// released level of the open-drain chain output
`define SSC_DOUT_RST 1'b1
// frame bit counter width and its saturation value
`define SSC_CNT_W 4
`define SSC_CNT_MAX 4'hf
// system clock period in ns
`define SSC_CLK_NS 10
// host serial clock half period in ns
`define SSC_HALF_NS 40
// half period in system clock cycles, rounded down, at least one
`define SSC_HALF_CYC ((`SSC_HALF_NS / `SSC_CLK_NS) < 1 ? 1 : (`SSC_HALF_NS / `SSC_CLK_NS))
// break-before-make gap in ns and in cycles, rounded up
`define SSC_BBM_NS 30
`define SSC_BBM_CYC ((`SSC_BBM_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)
`endif

//--- core/ssc_pkg.sv
// types shared by the host end and the bench of the serial switch control port
// assumes ssc_cfg.svh on the include path
`include "ssc_cfg.svh"
package ssc_pkg;
  // host transfer sequencer
  typedef enum logic [2:0] {
    SSC_IDLE,
    SSC_LEAD,
    SSC_HIGH,
    SSC_LOW,
    SSC_TRAIL
  } ssc_hstate_t;
  typedef logic [`SSC_WORD_W-1:0] ssc_word_t;
endpackage

//--- core/ssc_link_if.sv
// three-wire link plus open-drain chain output
// assumes an external pull-up on the chain line, modelled here
`timescale 1ns/1ps
interface ssc_link_if;
  logic sclk;
  logic sync_n;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic dout;
  // pull-up resolves the open-drain line
  assign dout = dout_oe ? dout_o : 1'b1;
  modport host (
    output sclk,
    output sync_n,
    output din,
    input  dout
  );
  modport dev (
    input  sclk,
    input  sync_n,
    input  din,
    output dout_o,
    output dout_oe
  );
endinterface // ssc_link_if

//--- core/ssc_dev.sv
// device end: shift register on the link clock, switches on clk_sys
// assumes the host stops the link clock outside frames
// and keeps sync high at least four system clocks between frames
`timescale 1ns/1ps
`include "ssc_cfg.svh"
module ssc_dev #(
  parameter int WORD_W  = `SSC_WORD_W,
  parameter int BBM_CYC = `SSC_BBM_CYC
) (
  // system side
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // link side
  ssc_link_if.dev                link,
  // switch drive
  output logic [WORD_W-1:0]      switch_on,
  output logic                   update_pulse,
  // last frame status
  output logic [`SSC_CNT_W-1:0]  frame_bits,
  output logic                   short_frame
);

  // link domain state
  logic [WORD_W-1:0]     shreg;
  logic [WORD_W-1:0]     next_shreg;
  logic [`SSC_CNT_W-1:0] bit_cnt;
  logic [`SSC_CNT_W-1:0] next_bit_cnt;
  logic                  pull_q;
  logic                  next_pull_q;
  logic                  fresh;
  // system domain state
  logic [2:0]            sync_sy;
  logic [2:0]            next_sync_sy;
  logic [WORD_W-1:0]     target;
  logic [WORD_W-1:0]     next_target;
  logic [WORD_W-1:0]     sw;
  logic [WORD_W-1:0]     next_sw;
  logic [7:0]            bbm_cnt;
  logic [7:0]            next_bbm_cnt;
  logic                  upd;
  logic                  next_upd;
  logic [`SSC_CNT_W-1:0] fbits;
  logic [`SSC_CNT_W-1:0] next_fbits;
  logic                  fshort;
  logic                  next_fshort;
  logic                  sync_rise;

  // capture on falling clock while framed
  always_comb
  begin
    next_shreg   = shreg;
    next_bit_cnt = bit_cnt;
    if (!link.sync_n)
    begin
      // oldest bit falls off the top, last eight kept
      next_shreg = {shreg[WORD_W-2:0], link.din};
      // first fall of a frame restarts the count at one, later falls count up, saturating at 15
      if (fresh)
        next_bit_cnt = `SSC_CNT_W'(1);
      else if (bit_cnt != `SSC_CNT_MAX)
        next_bit_cnt = bit_cnt + `SSC_CNT_W'(1);
    end
  end

  // frame start marker: held set while sync is high, so the count
  // needs no help from the other clock domain between frames
  always_ff @(negedge link.sclk or posedge link.sync_n)
  begin
    if (link.sync_n)
      fresh <= 1'b1;
    else
      fresh <= 1'b0;
  end

  // shift register and count; rst clears them asynchronously
  // because the link clock may be stopped during reset
  always_ff @(negedge link.sclk or posedge rst)
  begin
    if (rst)
    begin
      shreg   <= `SSC_WORD_RST;
      bit_cnt <= '0;
    end
    else
    begin
      shreg   <= next_shreg;
      bit_cnt <= next_bit_cnt;
    end
  end

  // chain output on rising clock, bit entered eight falls ago;
  // the flop holds the pull-down enable so the pin comes from a flop
  always_comb
  begin
    next_pull_q = pull_q;
    if (!link.sync_n)
      next_pull_q = ~shreg[WORD_W-1];
  end

  always_ff @(posedge link.sclk or posedge rst)
  begin
    if (rst)
      pull_q <= ~`SSC_DOUT_RST;
    else
      pull_q <= next_pull_q;
  end

  // pull low for zero, release for one; the level outside a frame
  // is whatever the last bit left, so it is only read inside frames
  assign link.dout_o  = 1'b0;
  assign link.dout_oe = pull_q;

  // sync rise detect after two-flop synchroniser
  always_comb
  begin
    next_sync_sy = {sync_sy[1:0], link.sync_n};
  end

  // third stage only feeds the edge detector, never the first
  assign sync_rise = sync_sy[1] & ~sync_sy[2];

  // word and count are quiet while sync is high, so a
  // qualified sample after the synchronised rise is safe
  always_comb
  begin
    next_target = target;
    next_upd    = 1'b0;
    next_fbits  = fbits;
    next_fshort = fshort;
    if (sync_rise)
    begin
      next_target = shreg;
      next_upd    = 1'b1;
      next_fbits  = bit_cnt;
      next_fshort = (bit_cnt < `SSC_CNT_W'(WORD_W));
    end
  end

  // break-before-make: switches turning off open at once,
  // switches turning on wait; switches staying on never blink
  // the gap keeps two inputs from ever being shorted in passing
  always_comb
  begin
    next_sw      = sw;
    next_bbm_cnt = bbm_cnt;
    if (sync_rise)
    begin
      next_sw      = sw & shreg;
      next_bbm_cnt = 8'(BBM_CYC);
    end
    else if (bbm_cnt != 8'h00)
    begin
      next_bbm_cnt = bbm_cnt - 8'h01;
      if (bbm_cnt == 8'h01)
        next_sw = target;
    end
  end

  // sync stages idle high in reset so no false rise follows it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync_sy <= 3'h7;
      target  <= `SSC_WORD_RST;
      sw      <= `SSC_WORD_RST;
      bbm_cnt <= 8'h00;
      upd     <= 1'b0;
      fbits   <= '0;
      fshort  <= 1'b0;
    end
    else
    begin
      sync_sy <= next_sync_sy;
      target  <= next_target;
      sw      <= next_sw;
      bbm_cnt <= next_bbm_cnt;
      upd     <= next_upd;
      fbits   <= next_fbits;
      fshort  <= next_fshort;
    end
  end

  // outputs straight from flip-flops
  assign switch_on    = sw;
  assign update_pulse = upd;
  assign frame_bits   = fbits;
  assign short_frame  = fshort;

endmodule // ssc_dev

//--- core/ssc_host.sv
// host end: makes the link clock by dividing clk_sys
// assumes chain line pulled up inside the interface
`timescale 1ns/1ps
`include "ssc_cfg.svh"
module ssc_host #(
  parameter int WORD_W   = `SSC_WORD_W,
  parameter int HALF_CYC = `SSC_HALF_CYC
) (
  // system side
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // user command port
  input  wire logic              start,
  input  wire logic [WORD_W-1:0] tx_word,
  output logic                   busy,
  output logic                   done,
  output logic [WORD_W-1:0]      rx_word,
  // link side
  ssc_link_if.host               link
);

  ssc_pkg::ssc_hstate_t state;
  ssc_pkg::ssc_hstate_t next_state;
  logic [7:0]           div;
  logic [7:0]           next_div;
  logic [3:0]           nbits;
  logic [3:0]           next_nbits;
  logic [WORD_W-1:0]    txs;
  logic [WORD_W-1:0]    next_txs;
  logic [WORD_W-1:0]    rxs;
  logic [WORD_W-1:0]    next_rxs;
  logic [WORD_W-1:0]    rxo;
  logic [WORD_W-1:0]    next_rxo;
  logic                 sclk_q;
  logic                 next_sclk_q;
  logic                 sync_q;
  logic                 next_sync_q;
  logic                 din_q;
  logic                 next_din_q;
  logic                 done_q;
  logic                 next_done_q;
  logic                 busy_q;
  logic                 next_busy_q;
  logic [1:0]           dout_sy;
  logic                 half_end;

  assign half_end = (div == 8'h00);

  // sequencer: lead, eight high/low pairs, trail
  always_comb
  begin
    next_state  = state;
    next_div    = half_end ? 8'(HALF_CYC - 1) : div - 8'h01;
    next_nbits  = nbits;
    next_txs    = txs;
    next_rxs    = rxs;
    next_rxo    = rxo;
    next_sclk_q = sclk_q;
    next_sync_q = sync_q;
    next_din_q  = din_q;
    next_done_q = 1'b0;
    case (state)
      ssc_pkg::SSC_IDLE:
      begin
        next_div = 8'(HALF_CYC - 1);
        if (start)
        begin
          next_sync_q = 1'b0;
          next_txs    = tx_word;
          next_nbits  = 4'(WORD_W);
          next_state  = ssc_pkg::SSC_LEAD;
        end
      end
      ssc_pkg::SSC_LEAD, ssc_pkg::SSC_LOW:
        if (half_end)
        begin
          if (nbits == 4'h0)
            next_state = ssc_pkg::SSC_TRAIL;
          else
          begin
            // data moves on the rising edge, msb first
            next_sclk_q = 1'b1;
            next_din_q  = txs[WORD_W-1];
            next_txs    = {txs[WORD_W-2:0], 1'b0};
            next_nbits  = nbits - 4'h1;
            next_state  = ssc_pkg::SSC_HIGH;
          end
        end
      ssc_pkg::SSC_HIGH:
        if (half_end)
        begin
          // late in the high phase the synced chain bit is settled
          next_rxs    = {rxs[WORD_W-2:0], dout_sy[1]};
          next_sclk_q = 1'b0;
          next_state  = ssc_pkg::SSC_LOW;
        end
      ssc_pkg::SSC_TRAIL:
        if (half_end)
        begin
          next_sync_q = 1'b1;
          next_rxo    = rxs;
          next_done_q = 1'b1;
          next_state  = ssc_pkg::SSC_IDLE;
        end
      default:
        next_state = ssc_pkg::SSC_IDLE;
    endcase
    // busy follows the frame line on the same edge
    next_busy_q = ~next_sync_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state   <= ssc_pkg::SSC_IDLE;
      div     <= 8'h00;
      nbits   <= 4'h0;
      txs     <= '0;
      rxs     <= '0;
      rxo     <= '0;
      sclk_q  <= 1'b0;
      sync_q  <= 1'b1;
      din_q   <= 1'b0;
      done_q  <= 1'b0;
      busy_q  <= 1'b0;
      dout_sy <= 2'h3;
    end
    else
    begin
      state   <= next_state;
      div     <= next_div;
      nbits   <= next_nbits;
      txs     <= next_txs;
      rxs     <= next_rxs;
      rxo     <= next_rxo;
      sclk_q  <= next_sclk_q;
      sync_q  <= next_sync_q;
      din_q   <= next_din_q;
      done_q  <= next_done_q;
      busy_q  <= next_busy_q;
      dout_sy <= {dout_sy[0], link.dout};
    end
  end

  // outputs straight from flip-flops
  assign link.sclk   = sclk_q;
  assign link.sync_n = sync_q;
  assign link.din    = din_q;
  assign busy        = busy_q;
  assign done        = done_q;
  assign rx_word     = rxo;

endmodule // ssc_host

//--- sim/ssc_link_chk.sv
// link checker: wire rules of both ends plus switch update timing
// assumes the host makes the link clock from clk_sys, which samples it
`timescale 1ns/1ps
module ssc_link_chk #(
  parameter int WORD_W = 8
) (
  // system clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // link wires
  input wire logic              sclk,
  input wire logic              sync_n,
  input wire logic              din,
  input wire logic              dout_o,
  input wire logic              dout_oe,
  input wire logic              dout,
  // device switch side
  input wire logic [WORD_W-1:0] switch_on,
  input wire logic              update_pulse
);
  logic [3:0] rises;
  logic [3:0] since;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // link clock rises per frame, cycles since frame end (saturating)
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rises <= 4'h0;
      since <= 4'hf;
    end
    else
    begin
      rises <= sync_n ? 4'h0 : rises + {3'h0, $rose(sclk)};
      since <= !sync_n ? 4'h0 : (since == 4'hf ? since : since + 4'h1);
    end
  end
  sequence s_frame_end;
    $rose(sync_n);
  endsequence
  sequence s_switch_update;
    ##[1:4] update_pulse;
  endsequence
  a_idle_clock_low: assert property (sync_n |-> !sclk)
    else $error("link clock high outside a frame");
  a_clock_in_frame: assert property ($rose(sclk) |-> !sync_n && !$past(sync_n))
    else $error("link clock rose without a frame");
  a_data_settled: assert property ($fell(sclk) |-> $stable(din))
    else $error("data moved at the sampling edge");
  a_data_on_rise: assert property ($changed(din) |-> $rose(sclk))
    else $error("data moved away from a clock rise");
  a_dout_on_rise: assert property ($changed(dout) |-> $rose(sclk) && !sync_n)
    else $error("chain output moved off a clock rise");
  a_open_drain: assert property (dout_oe |-> !dout_o)
    else $error("chain output driven high");
  a_eight_bits: assert property (s_frame_end |-> rises == 4'h8)
    else $error("frame did not carry eight bits");
  a_update_follows: assert property (s_frame_end |-> s_switch_update)
    else $error("no switch update after frame end");
  a_switch_settle: assert property ($changed(switch_on) |-> since <= 4'ha)
    else $error("switches moved away from a frame end");
endmodule // ssc_link_chk

//--- sim/tb_serial_switch_control_port.sv
// bench: host end drives the device end, a second device chained on dout
// assumes the core files and the link checker are compiled first
`timescale 1ns/1ps
module tb_serial_switch_control_port;
  logic               clk_sys;
  logic               rst;
  logic               start;
  logic               busy;
  logic               done;
  logic               update_pulse;
  ssc_pkg::ssc_word_t tx_word;
  ssc_pkg::ssc_word_t rx_word;
  ssc_pkg::ssc_word_t switch_on;
  ssc_pkg::ssc_word_t switch_far;
  ssc_pkg::ssc_word_t prev;
  ssc_pkg::ssc_word_t got;
  logic [3:0]         frame_bits;
  logic               short_frame;
  ssc_pkg::ssc_word_t words [5] = '{8'ha5, 8'hff, 8'h00, 8'h3c, 8'h81};
  int                 error_cnt = 0;
  int                 tests_run = 0;
  int                 cycles = 0;
  ssc_link_if link ();
  ssc_link_if link_far ();
  // far part shares clock and frame, fed from the chain line
  assign link_far.sclk   = link.sclk;
  assign link_far.sync_n = link.sync_n;
  assign link_far.din    = link.dout;
  ssc_host ssc_host_inst (.clk_sys(clk_sys), .rst(rst), .start(start), .tx_word(tx_word),
    .busy(busy), .done(done), .rx_word(rx_word), .link(link));
  ssc_dev ssc_dev_inst (.clk_sys(clk_sys), .rst(rst), .link(link), .switch_on(switch_on),
    .update_pulse(update_pulse), .frame_bits(frame_bits), .short_frame(short_frame));
  ssc_dev ssc_dev_inst2 (.clk_sys(clk_sys), .rst(rst), .link(link_far),
    .switch_on(switch_far), .update_pulse(), .frame_bits(), .short_frame());
  ssc_link_chk ssc_link_chk_inst (.clk_sys(clk_sys), .rst(rst), .sclk(link.sclk),
    .sync_n(link.sync_n), .din(link.din), .dout_o(link.dout_o), .dout_oe(link.dout_oe),
    .dout(link.dout), .switch_on(switch_on), .update_pulse(update_pulse));
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_word(input ssc_pkg::ssc_word_t act, input ssc_pkg::ssc_word_t exp);
    tests_run++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t word %h expected %h", $time, act, exp);
    end
  endtask
  task automatic chk_bit(input logic act, input logic exp);
    tests_run++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t bit %b expected %b", $time, act, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one frame; poke retries start mid-frame with other data, which must be refused
  task automatic write_word(input ssc_pkg::ssc_word_t word, input logic poke);
    int n;
    n = 0;
    start = 1'b1;
    tx_word = word;
    wait_cyc(1);
    start = 1'b0;
    tx_word = ~word;
    chk_bit(busy, 1'b1);
    while (done !== 1'b1 && n < 200)
    begin
      start = poke && n == 20;
      wait_cyc(1);
      n++;
    end
    chk_bit(done, 1'b1);
    chk_bit(busy, 1'b0);
  endtask
  // readback frame: sends the kept word again so the switches stay put
  task automatic read_word(input ssc_pkg::ssc_word_t keep, output ssc_pkg::ssc_word_t val);
    write_word(keep, 1'b0);
    val = rx_word;
  endtask
  // cycle ceiling well above seven frames of about seventy-five cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      final_report();
    end
  end
  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    tx_word = 8'h00;
    wait_cyc(5);
    rst = 1'b0;
    chk_word(switch_on, 8'h00);
    chk_bit(link.dout, 1'b1);
    $display("test reset done");
    prev = 8'h00;
    for (int i = 0; i < 5; i++)
    begin
      write_word(words[i], i == 2);
      chk_word(rx_word, prev);
      wait_cyc(10);
      chk_word(switch_on, words[i]);
      chk_word(switch_far, prev);
      chk_word(8'(frame_bits), 8'h08);
      chk_bit(short_frame, 1'b0);
      $display("test word %h done", words[i]);
      prev = words[i];
    end
    // readback rewrites the same word, switches must not move
    read_word(8'h81, got);
    chk_word(got, 8'h81);
    wait_cyc(10);
    chk_word(switch_on, 8'h81);
    chk_word(switch_far, 8'h81);
    $display("test readback done");
    // second reset mid-run clears switches and readback
    rst = 1'b1;
    wait_cyc(5);
    rst = 1'b0;
    chk_word(switch_on, 8'h00);
    write_word(8'h5a, 1'b0);
    chk_word(rx_word, 8'h00);
    wait_cyc(10);
    chk_word(switch_on, 8'h5a);
    $display("test second reset done");
    final_report();
  end
endmodule // tb_serial_switch_control_port
